// ==== core/ueif_regs.sv ====
// USB endpoint interrupt, FIFO access, byte count, frame number and clock divider registers.
//
// Contract
// - One interrupt enable bit per endpoint.
// - Reserved upper bits read zero, never written.
// - Any endpoint source sets its flag.
// - Sources: sent, out banks, setup, stall/crc.
// - Interrupt only when flag and enable set.
// - Flags read-only, cleared when sources clear.
// - FIFO register writes push, reads pop bytes.
// - FIFO and count follow selected endpoint.
// - Seven-bit received byte count, bit seven zero.
// - Eleven-bit frame number split over two registers.
// - Corrupted frame keeps stored frame number.
// - Good frame sets CRC-good bit five.
// - Corrupted frame sets CRC-bad bit four.
// - CRC bits reflect only latest frame.
// - Frame interrupt right after frame PID.
// - Two-bit field selects controller clock divider.
// - Setup sets its bit, clears others.
`timescale 1ns/100ps
module ueif_regs
  import ueif_pkg::*;
(
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire logic [7:0]               sfr_addr,
  input  wire logic                     sfr_wr,
  input  wire logic                     sfr_rd,
  input  wire logic [BYTE_W-1:0]        sfr_wdata,
  output logic [BYTE_W-1:0]             sfr_rdata,
  input  wire logic [EP_W-1:0]          selected_endpoint,
  input  wire logic [NUM_EP*ST_W-1:0]   status_set,
  input  wire logic [NUM_EP*ST_W-1:0]   status_clr,
  output logic [NUM_EP*ST_W-1:0]        endpoint_status,
  output logic [NUM_EP-1:0]             tx_valid,
  input  wire logic [NUM_EP-1:0]        tx_ready,
  output logic [NUM_EP*BYTE_W-1:0]      tx_data,
  input  wire logic                     rx_valid,
  output logic                          rx_ready,
  input  wire logic [BYTE_W-1:0]        rx_data,
  input  wire logic [EP_W-1:0]          rx_ep,
  input  wire logic                     rx_pkt_start,
  input  wire logic                     rx_pkt_end,
  input  wire logic                     sof_pid,
  input  wire logic                     sof_done,
  input  wire logic [FNUM_W-1:0]        sof_frame,
  input  wire logic                     sof_crc_ok,
  output logic                          sof_irq,
  output logic                          usb_irq,
  output logic                          usb_clk_en
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [NUM_EP-1:0]   irq_en_q;
  logic [ST_W-1:0]     status_q [NUM_EP];
  logic [NUM_EP-1:0]   ep_flags;
  logic [BCNT_W-1:0]   bcnt_q [NUM_EP];
  logic [BCNT_W-1:0]   pkt_cnt_q;
  logic [FNUM_W-1:0]   frame_q;
  logic                crc_good_q;
  logic                crc_bad_q;
  logic [CLKDIV_W-1:0] clkdiv_q;
  logic [CLKDIV_W-1:0] div_cnt_q;
  logic                usb_clk_en_q;
  logic                usb_irq_q;
  logic                sof_irq_q;
  logic [BYTE_W-1:0]   rdata_q;
  logic                wr_en;
  logic                wr_div;
  logic                wr_fifo;
  logic                rd_fifo;
  logic [NUM_EP-1:0]   rxf_valid;
  logic [NUM_EP-1:0]   rxf_in_ready;
  logic [BYTE_W-1:0]   rxf_data [NUM_EP];
  logic                rx_push;

  assign wr_en   = sfr_wr && (sfr_addr == ADDR_IRQ_ENABLE);
  assign wr_div  = sfr_wr && (sfr_addr == ADDR_CLOCK_DIV);
  assign wr_fifo = sfr_wr && (sfr_addr == ADDR_FIFO_DATA);
  assign rd_fifo = sfr_rd && (sfr_addr == ADDR_FIFO_DATA);

  // ----------------------------------------------------------------
  // Interrupt enable and clock divider fields
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_en_q <= RST_EN;
    end else if (wr_en) begin
      irq_en_q <= sfr_wdata[NUM_EP-1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clkdiv_q <= RST_CLKDIV;
    end else if (wr_div) begin
      clkdiv_q <= sfr_wdata[CLKDIV_W-1:0];
    end
  end

  // The controller clock is an enable pulse, one in every (select + 1) cycles.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_cnt_q    <= RST_CLKDIV;
      usb_clk_en_q <= 1'b0;
    end else begin
      if (div_cnt_q >= clkdiv_q) begin
        div_cnt_q    <= RST_CLKDIV;
        usb_clk_en_q <= 1'b1;
      end else begin
        div_cnt_q    <= div_cnt_q + 1'b1;
        usb_clk_en_q <= 1'b0;
      end
    end
  end

  assign usb_clk_en = usb_clk_en_q;

  // ----------------------------------------------------------------
  // Endpoint status sources and flags
  // ----------------------------------------------------------------
  for (genvar e = 0; e < NUM_EP; e++) begin : g_ep
    logic [ST_W-1:0] set_v;
    logic [ST_W-1:0] clr_v;

    assign set_v = status_set[e*ST_W +: ST_W];
    assign clr_v = status_clr[e*ST_W +: ST_W];

    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        status_q[e] <= RST_ST;
      end else if (set_v[ST_SETUP]) begin
        status_q[e] <= ST_SETUP_ONLY;
      end else begin
        // Sources held here.
        // A set arriving with its clear wins, so no event is lost.
        status_q[e] <= (status_q[e] & ~clr_v) | set_v;
      end
    end

    assign ep_flags[e] = |status_q[e];
    assign endpoint_status[e*ST_W +: ST_W] = status_q[e];
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      usb_irq_q <= 1'b0;
    end else begin
      usb_irq_q <= |(ep_flags & irq_en_q);
    end
  end

  assign usb_irq = usb_irq_q;

  // ----------------------------------------------------------------
  // Endpoint FIFOs
  // ----------------------------------------------------------------
  // Each endpoint owns a transmit and a receive FIFO, so pointers never mix.
  for (genvar e = 0; e < NUM_EP; e++) begin : g_fifo
    ueif_fifo #(
      .W (BYTE_W),
      .D (FIFO_DEPTH)
    ) u_tx (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .in_valid  (wr_fifo && (selected_endpoint == EP_W'(e))),
      .in_ready  (),
      .in_data   (sfr_wdata),
      .out_valid (tx_valid[e]),
      .out_ready (tx_ready[e]),
      .out_data  (tx_data[e*BYTE_W +: BYTE_W])
    );

    ueif_fifo #(
      .W (BYTE_W),
      .D (FIFO_DEPTH)
    ) u_rx (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .in_valid  (rx_valid && (rx_ep == EP_W'(e))),
      .in_ready  (rxf_in_ready[e]),
      .in_data   (rx_data),
      .out_valid (rxf_valid[e]),
      .out_ready (rd_fifo && (selected_endpoint == EP_W'(e))),
      .out_data  (rxf_data[e])
    );
  end

  // The receive side stalls while the addressed endpoint FIFO is full.
  assign rx_ready = (rx_ep < EP_W'(NUM_EP)) ? rxf_in_ready[rx_ep] : 1'b0;
  assign rx_push  = rx_valid && rx_ready;

  // ----------------------------------------------------------------
  // Received byte count
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pkt_cnt_q <= RST_BCNT;
    end else if (rx_pkt_start) begin
      pkt_cnt_q <= RST_BCNT;
    end else if (rx_push) begin
      pkt_cnt_q <= pkt_cnt_q + 1'b1;
    end
  end

  for (genvar e = 0; e < NUM_EP; e++) begin : g_bcnt
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        bcnt_q[e] <= RST_BCNT;
      end else if (rx_pkt_end && (rx_ep == EP_W'(e))) begin
        bcnt_q[e] <= rx_push ? pkt_cnt_q + 1'b1 : pkt_cnt_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Start of frame capture
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sof_irq_q <= 1'b0;
    end else begin
      sof_irq_q <= sof_pid;
    end
  end

  assign sof_irq = sof_irq_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      frame_q    <= RST_FNUM;
      crc_good_q <= 1'b0;
      crc_bad_q  <= 1'b0;
    end else if (sof_done) begin
      crc_good_q <= sof_crc_ok;
      crc_bad_q  <= !sof_crc_ok;
      if (sof_crc_ok) begin
        frame_q <= sof_frame;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  // Read data appears the cycle after the read strobe; a FIFO read pops on that edge.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= RST_BYTE;
    end else if (sfr_rd) begin
      if (sfr_addr == ADDR_IRQ_ENABLE) begin
        rdata_q <= {{(BYTE_W-NUM_EP){1'b0}}, irq_en_q};
      end else if (sfr_addr == ADDR_IRQ_FLAGS) begin
        rdata_q <= {{(BYTE_W-NUM_EP){1'b0}}, ep_flags};
      end else if (sfr_addr == ADDR_FIFO_DATA) begin
        rdata_q <= (selected_endpoint < EP_W'(NUM_EP)) ? rxf_data[selected_endpoint] : RST_BYTE;
      end else if (sfr_addr == ADDR_BYTE_COUNT) begin
        rdata_q <= (selected_endpoint < EP_W'(NUM_EP)) ? {1'b0, bcnt_q[selected_endpoint]} : RST_BYTE;
      end else if (sfr_addr == ADDR_FRAME_LOW) begin
        rdata_q <= frame_q[FNUM_LO_W-1:0];
      end else if (sfr_addr == ADDR_FRAME_HIGH) begin
        rdata_q <= {2'b00, crc_good_q, crc_bad_q, 1'b0, frame_q[FNUM_W-1:FNUM_LO_W]};
      end else if (sfr_addr == ADDR_CLOCK_DIV) begin
        rdata_q <= {{(BYTE_W-CLKDIV_W){1'b0}}, clkdiv_q};
      end else begin
        rdata_q <= RST_BYTE;
      end
    end
  end

  assign sfr_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_EN_WRITE: assert property (wr_en |=> irq_en_q == $past(sfr_wdata[NUM_EP-1:0]))
    else $error("enable bits not stored");
  AST_RSVD_READ: assert property ((sfr_rd && (sfr_addr == ADDR_IRQ_ENABLE || sfr_addr == ADDR_IRQ_FLAGS))
    |=> sfr_rdata[BYTE_W-1:NUM_EP] == '0)
    else $error("reserved bits read nonzero");
  AST_FLAG_SET: assert property (|status_set[ST_W-1:0] |=> ep_flags[0])
    else $error("flag not set by source");
  AST_IRQ_GATE: assert property (((status_q[0] != RST_ST) && irq_en_q[0]) |=> usb_irq)
    else $error("interrupt gating wrong");
  AST_FLAG_CLR: assert property ((ep_flags[1] && ((status_q[1] & ~status_clr[ST_W +: ST_W]) == RST_ST)
    && (status_set[ST_W +: ST_W] == RST_ST)) |=> !ep_flags[1])
    else $error("flag stays with no source");
  AST_SETUP: assert property (status_set[ST_SETUP] |=> status_q[0] == ST_SETUP_ONLY)
    else $error("setup did not clear others");
  AST_SOF_BAD: assert property ((sof_done && !sof_crc_ok) |=> $stable(frame_q) && crc_bad_q && !crc_good_q)
    else $error("corrupted frame handled wrong");
  AST_SOF_GOOD: assert property ((sof_done && sof_crc_ok) |=> frame_q == $past(sof_frame) && crc_good_q && !crc_bad_q)
    else $error("good frame handled wrong");
  AST_SOF_IRQ: assert property (sof_pid |=> sof_irq)
    else $error("frame interrupt late");
  AST_BCNT_RSVD: assert property ((sfr_rd && sfr_addr == ADDR_BYTE_COUNT) |=> !sfr_rdata[BYTE_W-1])
    else $error("byte count bit seven set");
  AST_DIV_ONE: assert property ((clkdiv_q == RST_CLKDIV && !wr_div) [*2] |-> usb_clk_en)
    else $error("divide by one not continuous");

endmodule // ueif_regs

// ==== core/ueif_pkg.sv ====
// Shared constants for the USB endpoint interrupt, FIFO and frame-number register slice.
package ueif_pkg;

  // ----------------------------------------------------------------
  // Register addresses in the special-function register space
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_FRAME_LOW   = 8'hBA;
  localparam logic [7:0] ADDR_FRAME_HIGH  = 8'hBB;
  localparam logic [7:0] ADDR_IRQ_ENABLE  = 8'hC2;
  localparam logic [7:0] ADDR_FIFO_DATA   = 8'hCF;
  localparam logic [7:0] ADDR_BYTE_COUNT  = 8'hE2;
  localparam logic [7:0] ADDR_CLOCK_DIV   = 8'hEA;
  localparam logic [7:0] ADDR_IRQ_FLAGS   = 8'hF8;

  // ----------------------------------------------------------------
  // Widths and depths
  // ----------------------------------------------------------------
  localparam int NUM_EP      = 3;
  localparam int EP_W        = 2;
  localparam int BYTE_W      = 8;
  localparam int FIFO_DEPTH  = 8;
  localparam int FNUM_W      = 11;
  localparam int FNUM_LO_W   = 8;
  localparam int FNUM_HI_W   = 3;
  localparam int BCNT_W      = 7;
  localparam int CLKDIV_W    = 2;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int POS_CRC_GOOD = 5;
  localparam int POS_CRC_BAD  = 4;

  // Endpoint status sources, one vector per endpoint.
  localparam int ST_IN_SENT    = 0;
  localparam int ST_OUT_BANK0  = 1;
  localparam int ST_SETUP      = 2;
  localparam int ST_STALL_CRC  = 3;
  localparam int ST_OUT_BANK1  = 4;
  localparam int ST_W          = 5;

  localparam logic [ST_W-1:0] ST_SETUP_ONLY = 5'h04;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [BYTE_W-1:0]   RST_BYTE   = 8'h00;
  localparam logic [NUM_EP-1:0]   RST_EN     = 3'h0;
  localparam logic [FNUM_W-1:0]   RST_FNUM   = 11'h000;
  localparam logic [CLKDIV_W-1:0] RST_CLKDIV = 2'h0;
  localparam logic [BCNT_W-1:0]   RST_BCNT   = 7'h00;
  localparam logic [ST_W-1:0]     RST_ST     = 5'h00;

endpackage

// ==== core/ueif_fifo.sv ====
// Byte FIFO with valid/ready handshakes on both sides.
`timescale 1ns/100ps
module ueif_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int AW = $clog2(D);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0]   count_q;
  logic          push;
  logic          pop;

  assign in_ready  = (count_q != (AW+1)'(D));
  assign out_valid = (count_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_q];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(D-1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(D-1)) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule // ueif_fifo

// ==== verification/ueif_host_model.sv ====
// Far-side model of the USB engine: endpoint events, OUT bytes, frame markers and IN drain.
`timescale 1ns/100ps
module ueif_host_model
  import ueif_pkg::*;
(
  input  wire logic                     sys_clk,
  output logic [NUM_EP*ST_W-1:0]        status_set,
  input  wire logic [NUM_EP-1:0]        tx_valid,
  output logic [NUM_EP-1:0]             tx_ready,
  input  wire logic [NUM_EP*BYTE_W-1:0] tx_data,
  output logic                          rx_valid,
  input  wire logic                     rx_ready,
  output logic [BYTE_W-1:0]             rx_data,
  output logic [EP_W-1:0]               rx_ep,
  output logic                          rx_pkt_start,
  output logic                          rx_pkt_end,
  output logic                          sof_pid,
  output logic                          sof_done,
  output logic [FNUM_W-1:0]             sof_frame,
  output logic                          sof_crc_ok
);
  // ----------------------------------------------------------------
  // Engine events, driven one step after the rising edge
  // ----------------------------------------------------------------
  initial begin
    status_set   = '0;
    tx_ready     = '0;
    rx_valid     = 1'b0;
    rx_data      = 8'h00;
    rx_ep        = 2'h0;
    rx_pkt_start = 1'b0;
    rx_pkt_end   = 1'b0;
    sof_pid      = 1'b0;
    sof_done     = 1'b0;
    sof_frame    = 11'h000;
    sof_crc_ok   = 1'b0;
  end

  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic raise(input int ep, input logic [ST_W-1:0] bits);
    status_set[ep*ST_W +: ST_W] = bits;
    tick();
    status_set = '0;
    tick();
  endtask

  // OUT byte stream
  // Idle data lines carry the inverted last byte, so a stale value can never look right.
  task automatic send_pkt(input logic [EP_W-1:0] ep, input int n, input logic [7:0] base, output logic ok);
    int i;
    int t;
    ok = 1'b1;
    rx_ep = ep;
    rx_pkt_start = 1'b1;
    tick();
    rx_pkt_start = 1'b0;
    for (i = 0; i < n; i++) begin
      rx_data  = base + 8'(i);
      rx_valid = 1'b1;
      t = 0;
      while (rx_ready !== 1'b1 && t < 50) begin
        tick();
        t++;
      end
      ok = ok & (t < 50);
      tick();
    end
    rx_valid = 1'b0;
    rx_data = ~rx_data;
    rx_pkt_end = 1'b1;
    tick();
    rx_pkt_end = 1'b0;
    tick();
  endtask

  task automatic take_tx(input int ep, output logic [7:0] b, output logic ok);
    int t;
    t = 0;
    while (tx_valid[ep] !== 1'b1 && t < 50) begin
      tick();
      t++;
    end
    ok = (t < 50);
    tx_ready[ep] = 1'b1;
    // The head byte is settled between edges, so it is taken before the popping edge.
    b = tx_data[ep*BYTE_W +: BYTE_W];
    tick();
    tx_ready[ep] = 1'b0;
    tick();
  endtask

  task automatic sof_begin();
    sof_pid = 1'b1;
    tick();
    sof_pid = 1'b0;
  endtask

  task automatic sof_end(input logic [FNUM_W-1:0] frame, input logic good);
    sof_frame  = frame;
    sof_crc_ok = good;
    sof_done   = 1'b1;
    tick();
    sof_done   = 1'b0;
    sof_frame  = ~frame;
    sof_crc_ok = ~good;
    tick();
  endtask
endmodule // ueif_host_model

// ==== verification/ueif_regs_tb_top.sv ====
// Self-checking bench for the endpoint interrupt, FIFO, byte count and frame number registers.
`timescale 1ns/100ps
module ueif_regs_tb_top
  import ueif_pkg::*;
;
  logic                     sys_clk, rst, sfr_wr, sfr_rd, rx_valid, rx_ready, rx_pkt_start, rx_pkt_end;
  logic                     sof_pid, sof_done, sof_crc_ok, sof_irq, usb_irq, usb_clk_en, ok;
  logic [7:0]               sfr_addr, sfr_wdata, sfr_rdata, rx_data, b;
  logic [EP_W-1:0]          selected_endpoint, rx_ep;
  logic [NUM_EP*ST_W-1:0]   status_set, status_clr, endpoint_status;
  logic [NUM_EP-1:0]        tx_valid, tx_ready;
  logic [NUM_EP*BYTE_W-1:0] tx_data;
  logic [FNUM_W-1:0]        sof_frame;
  int                       mismatches, n_checks, cyc, i, s, n;

  ueif_regs u_dut (.sys_clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .selected_endpoint,
    .status_set, .status_clr, .endpoint_status, .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_ready, .rx_data,
    .rx_ep, .rx_pkt_start, .rx_pkt_end, .sof_pid, .sof_done, .sof_frame, .sof_crc_ok, .sof_irq, .usb_irq,
    .usb_clk_en);
  ueif_host_model u_host (.sys_clk, .status_set, .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_ready, .rx_data,
    .rx_ep, .rx_pkt_start, .rx_pkt_end, .sof_pid, .sof_done, .sof_frame, .sof_crc_ok);

  // ----------------------------------------------------------------
  // Bus cycles and comparison
  // ----------------------------------------------------------------
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    tick();
    sfr_wr    = 1'b0;
    tick();
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    sfr_addr = a;
    sfr_rd   = 1'b1;
    tick();
    sfr_rd   = 1'b0;
    chk(what, exp, sfr_rdata);
    tick();
  endtask

  task automatic clr(input int ep, input logic [ST_W-1:0] bits);
    status_clr[ep*ST_W +: ST_W] = bits;
    tick();
    status_clr = '0;
    tick();
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_cfg();
    rdchk("frame_low", ADDR_FRAME_LOW, 8'h00);
    rdchk("irq_enable", ADDR_IRQ_ENABLE, 8'h00);
    rdchk("unmapped", 8'h10, 8'h00);
    wr(ADDR_IRQ_ENABLE, 8'h07);
    rdchk("irq_enable", ADDR_IRQ_ENABLE, 8'h07);
    wr(ADDR_CLOCK_DIV, 8'h03);
    rdchk("clock_div", ADDR_CLOCK_DIV, 8'h03);
    for (s = 0; s < 4; s++) begin
      wr(ADDR_CLOCK_DIV, 8'(s));
      repeat (4) tick();
      n = 0;
      repeat (12) begin
        tick();
        n += int'(usb_clk_en);
      end
      chk("clk_en_count", 8'(12 / (s + 1)), 8'(n));
    end
  endtask

  task automatic t_irq();
    for (i = 0; i < NUM_EP; i++) begin
      for (s = 0; s < ST_W; s++) begin
        u_host.raise(i, 5'(1 << s));
        chk("usb_irq", 8'h01, {7'h00, usb_irq});
        chk("status", 8'(1 << s), {3'h0, endpoint_status[i*ST_W +: ST_W]});
        rdchk("flags", ADDR_IRQ_FLAGS, 8'(1 << i));
        clr(i, 5'(1 << s));
        rdchk("flags_clear", ADDR_IRQ_FLAGS, 8'h00);
      end
    end
    u_host.raise(2, 5'h02);
    wr(ADDR_IRQ_ENABLE, 8'h03);
    chk("usb_irq_masked", 8'h00, {7'h00, usb_irq});
    wr(ADDR_IRQ_FLAGS, 8'h07);
    rdchk("flags_ro", ADDR_IRQ_FLAGS, 8'h04);
    wr(ADDR_IRQ_ENABLE, 8'h07);
    chk("usb_irq_unmasked", 8'h01, {7'h00, usb_irq});
    clr(2, 5'h02);
    u_host.raise(0, 5'h01);
    u_host.raise(0, 5'h1F);
    chk("setup_only", 8'h04, {3'h0, endpoint_status[ST_W-1:0]});
    rdchk("flags_setup", ADDR_IRQ_FLAGS, 8'h01);
    clr(0, 5'h1F);
  endtask

  // The engine stalls while the CPU fills the FIFO past its depth; the extra byte is dropped.
  task automatic t_tx();
    selected_endpoint = 2'd1;
    for (i = 0; i < 9; i++) wr(ADDR_FIFO_DATA, 8'hA0 + 8'(i));
    chk("tx_valid", 8'h02, {5'h00, tx_valid});
    for (i = 0; i < 8; i++) begin
      u_host.take_tx(1, b, ok);
      chk("tx_wait", 8'h01, {7'h00, ok});
      chk("tx_byte", 8'hA0 + 8'(i), b);
    end
    chk("tx_empty", 8'h00, {5'h00, tx_valid});
  endtask

  task automatic t_rx();
    selected_endpoint = 2'd2;
    u_host.send_pkt(2'd2, 8, 8'h30, ok);
    chk("rx_wait", 8'h01, {7'h00, ok});
    chk("rx_ready_full", 8'h00, {7'h00, rx_ready});
    rdchk("byte_count", ADDR_BYTE_COUNT, 8'h08);
    selected_endpoint = 2'd0;
    u_host.send_pkt(2'd0, 3, 8'h50, ok);
    rdchk("byte_count_ep0", ADDR_BYTE_COUNT, 8'h03);
    for (i = 0; i < 3; i++) rdchk("rx_byte_ep0", ADDR_FIFO_DATA, 8'h50 + 8'(i));
    selected_endpoint = 2'd2;
    rdchk("byte_count_ep2", ADDR_BYTE_COUNT, 8'h08);
    for (i = 0; i < 8; i++) rdchk("rx_byte", ADDR_FIFO_DATA, 8'h30 + 8'(i));
  endtask

  task automatic t_sof();
    u_host.sof_begin();
    chk("sof_irq", 8'h01, {7'h00, sof_irq});
    rdchk("frame_high_pending", ADDR_FRAME_HIGH, 8'h00);
    u_host.sof_end(11'h5A3, 1'b1);
    rdchk("frame_low", ADDR_FRAME_LOW, 8'hA3);
    rdchk("frame_high", ADDR_FRAME_HIGH, 8'h25);
    u_host.sof_begin();
    u_host.sof_end(11'h2FF, 1'b0);
    rdchk("frame_low_kept", ADDR_FRAME_LOW, 8'hA3);
    rdchk("frame_high_bad", ADDR_FRAME_HIGH, 8'h15);
    u_host.sof_begin();
    u_host.sof_end(11'h001, 1'b1);
    wr(ADDR_FRAME_LOW, 8'hFF);
    rdchk("frame_low_new", ADDR_FRAME_LOW, 8'h01);
    rdchk("frame_high_new", ADDR_FRAME_HIGH, 8'h20);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      summarize();
    end
  end

  initial begin
    rst = 1'b1;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    selected_endpoint = 2'd0;
    status_clr = '0;
    repeat (3) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    t_cfg();
    t_irq();
    t_tx();
    t_rx();
    t_sof();
    summarize();
  end
endmodule // ueif_regs_tb_top
